//--- mpfc_pkg.sv
// Constants, register map and types of the MAC pause flow control block
package mpfc_pkg;

  // Clock and pause quantum timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUANT_NS_1G = 512;
  localparam int QUANT_NS_100M = 5120;
  localparam int QUANT_NS_10M = 51200;
  localparam int QUANT_CYC_1G = (QUANT_NS_1G + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int QUANT_CYC_100M = (QUANT_NS_100M + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  localparam int QUANT_CYC_10M = (QUANT_NS_10M + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int QCNT_W = 13;

  // Frame constants
  localparam logic [47:0] CTRL_MCAST_DA = 48'h0180C2000001;
  localparam logic [15:0] CTRL_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam int CTRL_FRAME_BYTES = 64;
  localparam int PAUSE_GEN_BYTES = 60;
  localparam logic [5:0] PAUSE_LAST_IDX = 6'(PAUSE_GEN_BYTES - 1);
  localparam int DA_BYTES = 6;
  localparam int HDR_FIRST = 12;
  localparam int HDR_LAST = 17;
  localparam int RX_CNT_W = 14;

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STA_LO = 8'h04;
  localparam logic [7:0] REG_STA_HI = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ACTED = 8'h10;

  // Config fields and reset value
  localparam int CFG_TX_FC_BIT = 0;
  localparam int CFG_RX_FC_BIT = 1;
  localparam int CFG_LEN_CHK_BIT = 2;
  localparam int CFG_SPEED_LSB = 4;
  localparam logic [1:0] SPEED_10M = 2'h0;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_1G = 2'h2;
  localparam logic [31:0] CONFIG_RST = 32'h00000027;
  localparam logic [47:0] STA_RST = 48'h000000000000;

  // Status fields
  localparam int STS_INHIBIT_BIT = 0;
  localparam int STS_PEND_BIT = 1;
  localparam int STS_REMAIN_LSB = 16;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_PAUSE = 3'b010,
    TX_USER = 3'b100
  } mpfc_tx_e;

endpackage : mpfc_pkg

//--- mpfc_tx_frame.sv
// Byte generator for an outgoing pause control frame (DA through pad)
module mpfc_tx_frame (
  input wire logic [5:0] idx,
  input wire logic [47:0] sta,
  input wire logic [15:0] param,
  output logic [7:0] tx_byte
);
  import mpfc_pkg::*;

  always_comb begin
    tx_byte = 8'h00;
    case (idx)
      6'd0: tx_byte = CTRL_MCAST_DA[47:40];
      6'd1: tx_byte = CTRL_MCAST_DA[39:32];
      6'd2: tx_byte = CTRL_MCAST_DA[31:24];
      6'd3: tx_byte = CTRL_MCAST_DA[23:16];
      6'd4: tx_byte = CTRL_MCAST_DA[15:8];
      6'd5: tx_byte = CTRL_MCAST_DA[7:0];
      6'd6: tx_byte = sta[7:0];
      6'd7: tx_byte = sta[15:8];
      6'd8: tx_byte = sta[23:16];
      6'd9: tx_byte = sta[31:24];
      6'd10: tx_byte = sta[39:32];
      6'd11: tx_byte = sta[47:40];
      6'd12: tx_byte = CTRL_TYPE[15:8];
      6'd13: tx_byte = CTRL_TYPE[7:0];
      6'd14: tx_byte = PAUSE_OPCODE[15:8];
      6'd15: tx_byte = PAUSE_OPCODE[7:0];
      6'd16: tx_byte = param[15:8];
      6'd17: tx_byte = param[7:0];
      default: tx_byte = 8'h00;
    endcase
  end

endmodule : mpfc_tx_frame

//--- mpfc_pause_timer.sv
// Pause quanta timer that holds off the transmitter
module mpfc_pause_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [mpfc_pkg::QCNT_W-1:0] q_cycles,
  output logic active,
  output logic [15:0] remaining
);
  import mpfc_pkg::*;

  logic [15:0] quanta_r;
  logic [QCNT_W-1:0] sub_r;
  wire sub_done = (sub_r <= QCNT_W'(1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      quanta_r <= 16'h0000;
      sub_r <= '0;
    end else if (load) begin
      // New value replaces the running one; zero cancels at once
      quanta_r <= load_val;
      sub_r <= q_cycles;
    end else if (quanta_r != 16'h0000) begin
      if (sub_done) begin
        quanta_r <= quanta_r - 16'h0001;
        sub_r <= q_cycles;
      end else begin
        sub_r <= sub_r - QCNT_W'(1);
      end
    end
  end

  assign active = (quanta_r != 16'h0000);
  assign remaining = quanta_r;

  property p_reload;
    @(posedge clk) disable iff (!rst_b)
    load |=> (remaining == $past(load_val));
  endproperty
  a_reload: assert property (p_reload)
    else $error("pause timer did not reload with the received value");

  property p_quantum_hold;
    @(posedge clk) disable iff (!rst_b)
    (active && !load && !sub_done) |=> (remaining == $past(remaining));
  endproperty
  a_quantum_hold: assert property (p_quantum_hold)
    else $error("pause quantum ended before its bit time count");

endmodule : mpfc_pause_timer

//--- mpfc_flow_ctrl.sv
// Pause frame flow control: pause send, pause receive and transmit hold-off

// Overview of operation
// - With transmit flow control on, a request sends a pause frame.
// - Request and duration are driven and sampled on this clock.
// - Pause frame uses control multicast DA and station address as SA.
// - Idle sends at once; busy finishes frame, then pause precedes user.
// - Local pause frames go out even while user frames are held off.
// - One pending request; repeats yield one frame with latest duration.
// - Flow control off: control frames from user pass as normal frames.
// - Received control frame is error-free only if good and 64 bytes.
// - Control frame failing checks is forwarded marked bad.
// - Pause reception off: good control frame forwarded as normal.
// - Match DA to multicast or station, type to 88-08, then opcode.
// - Valid pause with size condition holds transmitter for its quanta.
// - Hold-off withholds user stream ready until the interval ends.
// - A pause frame acted upon is forwarded marked bad.
// - Length check on: control type not 64 bytes is ignored, marked bad.
// - Any address, type or opcode mismatch: ignored, marked good.
// - Every received control frame raises the control statistics bit.
// - A zero duration pause ends a running pause at once.
// - One pause quantum is 512 bit times at the selected speed; at 1G the code rounds up to 52 clocks, 520 ns.
// - The control type code is 88-08.
module mpfc_flow_ctrl #(
  parameter int unsigned QUANT_CYC_10M_P = mpfc_pkg::QUANT_CYC_10M
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [mpfc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pause_req,
  input wire logic [15:0] pause_val,
  input wire logic [7:0] tx_tdata,
  input wire logic tx_tvalid,
  input wire logic tx_tlast,
  output logic tx_tready,
  output logic [7:0] tx_line_data,
  output logic tx_line_valid,
  output logic tx_line_last,
  input wire logic [7:0] rx_line_data,
  input wire logic rx_line_valid,
  input wire logic rx_line_last,
  input wire logic rx_line_good,
  output logic [7:0] rx_tdata,
  output logic rx_tvalid,
  output logic rx_tlast,
  output logic rx_tuser_bad,
  output logic rx_stat_ctrl
);
  import mpfc_pkg::*;

  // Registers
  logic [31:0] config_r;
  logic [31:0] sta_lo_r;
  logic [15:0] sta_hi_r;
  logic [15:0] acted_r;
  logic [31:0] rdata_r;

  wire tx_fc_en = config_r[CFG_TX_FC_BIT];
  wire rx_fc_en = config_r[CFG_RX_FC_BIT];
  wire len_chk_en = config_r[CFG_LEN_CHK_BIT];
  wire [1:0] speed = config_r[CFG_SPEED_LSB +: 2];
  wire [47:0] sta = {sta_hi_r, sta_lo_r};

  // Transmit side state
  mpfc_tx_e tx_st_r;
  mpfc_tx_e tx_st_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [15:0] val_r;
  logic [15:0] send_param_r;
  logic [5:0] pidx_r;
  logic [7:0] frame_byte;

  // Receive side state
  logic [RX_CNT_W-1:0] rx_cnt_r;
  logic [47:0] da_r;
  logic [47:0] hdr_r;

  // Timer interface
  logic inhibit;
  logic [15:0] remaining;
  logic [QCNT_W-1:0] q_cyc;

  // Register bus decode
  wire wr_config = reg_wr && (reg_addr == REG_CONFIG);
  wire wr_sta_lo = reg_wr && (reg_addr == REG_STA_LO);
  wire wr_sta_hi = reg_wr && (reg_addr == REG_STA_HI);
  wire [31:0] status_word = {remaining, 14'h0000, pend_r, inhibit};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      REG_CONFIG: rd_mux = config_r;
      REG_STA_LO: rd_mux = sta_lo_r;
      REG_STA_HI: rd_mux = {16'h0000, sta_hi_r};
      REG_STATUS: rd_mux = status_word;
      REG_ACTED: rd_mux = {16'h0000, acted_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      config_r <= CONFIG_RST;
      sta_lo_r <= STA_RST[31:0];
      sta_hi_r <= STA_RST[47:32];
    end else begin
      if (wr_config) begin
        config_r <= reg_wdata;
      end
      if (wr_sta_lo) begin
        sta_lo_r <= reg_wdata;
      end
      if (wr_sta_hi) begin
        sta_hi_r <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h00000000;
    end
  end
  assign reg_rdata = rdata_r;

  // Pause request capture: one pending slot, latest duration kept
  wire fc_req = pause_req && tx_fc_en;
  wire start_pause = (tx_st_r == TX_IDLE) && pend_r && tx_fc_en;
  wire start_user = (tx_st_r == TX_IDLE) && !start_pause && tx_tvalid &&
                    !inhibit;
  wire pause_end = (tx_st_r == TX_PAUSE) && (pidx_r == PAUSE_LAST_IDX);
  wire user_end = (tx_st_r == TX_USER) && tx_tvalid && tx_tlast;

  // A request in the start cycle stays pending for a second frame
  assign pend_nxt = fc_req ? 1'b1 :
                    (start_pause || !tx_fc_en) ? 1'b0 : pend_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
      val_r <= 16'h0000;
    end else begin
      pend_r <= pend_nxt;
      if (fc_req) begin
        val_r <= pause_val;
      end
    end
  end

  // Transmit arbiter: pause frames win over user frames at frame borders
  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      TX_IDLE: begin
        if (start_pause) begin
          tx_st_nxt = TX_PAUSE;
        end else if (start_user) begin
          tx_st_nxt = TX_USER;
        end
      end
      TX_PAUSE: begin
        if (pause_end) begin
          tx_st_nxt = TX_IDLE;
        end
      end
      TX_USER: begin
        if (user_end) begin
          tx_st_nxt = TX_IDLE;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_st_r <= TX_IDLE;
      pidx_r <= 6'd0;
      send_param_r <= 16'h0000;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (start_pause) begin
        send_param_r <= val_r;
        pidx_r <= 6'd0;
      end else if (tx_st_r == TX_PAUSE) begin
        pidx_r <= pidx_r + 6'd1;
      end
    end
  end

  mpfc_tx_frame u_tx_frame (
    .idx(pidx_r),
    .sta(sta),
    .param(send_param_r),
    .tx_byte(frame_byte)
  );

  // User frames, control frames included, pass unchanged
  assign tx_tready = (tx_st_r == TX_USER);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_line_data <= 8'h00;
      tx_line_valid <= 1'b0;
      tx_line_last <= 1'b0;
    end else if (tx_st_r == TX_PAUSE) begin
      tx_line_data <= frame_byte;
      tx_line_valid <= 1'b1;
      tx_line_last <= pause_end;
    end else if (tx_st_r == TX_USER) begin
      tx_line_data <= tx_tdata;
      tx_line_valid <= tx_tvalid;
      tx_line_last <= tx_tvalid && tx_tlast;
    end else begin
      tx_line_valid <= 1'b0;
      tx_line_last <= 1'b0;
    end
  end

  // Receive header capture
  wire rx_end = rx_line_valid && rx_line_last;
  wire in_da = (rx_cnt_r < RX_CNT_W'(DA_BYTES));
  wire in_hdr = (rx_cnt_r >= RX_CNT_W'(HDR_FIRST)) &&
                (rx_cnt_r <= RX_CNT_W'(HDR_LAST));
  wire [RX_CNT_W-1:0] cnt_sat = {RX_CNT_W{1'b1}};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_cnt_r <= '0;
      da_r <= 48'h000000000000;
      hdr_r <= 48'h000000000000;
    end else if (rx_line_valid) begin
      if (rx_line_last) begin
        rx_cnt_r <= '0;
      end else if (rx_cnt_r != cnt_sat) begin
        rx_cnt_r <= rx_cnt_r + RX_CNT_W'(1);
      end
      if (in_da) begin
        da_r <= {da_r[39:0], rx_line_data};
      end
      if (in_hdr) begin
        hdr_r <= {hdr_r[39:0], rx_line_data};
      end
    end
  end

  // Station address in wire order for the destination compare
  logic [47:0] sta_wire;
  for (genvar g = 0; g < DA_BYTES; g++) begin : g_sta_swap
    assign sta_wire[47-8*g -: 8] = sta[8*g +: 8];
  end

  // Frame decision at the last byte
  wire [15:0] rx_type = hdr_r[47:32];
  wire [15:0] rx_opcode = hdr_r[31:16];
  wire [15:0] rx_param = hdr_r[15:0];
  wire is_ctrl = (rx_type == CTRL_TYPE);
  wire len64 = (rx_cnt_r == RX_CNT_W'(CTRL_FRAME_BYTES - 1));
  wire da_hit = (da_r == CTRL_MCAST_DA) || (da_r == sta_wire);
  wire op_hit = is_ctrl && (rx_opcode == PAUSE_OPCODE);
  wire size_ok = len64 || !len_chk_en;
  wire len_bad = is_ctrl && len_chk_en && !len64;
  wire act = rx_end && rx_line_good && rx_fc_en && !len_bad && da_hit &&
             op_hit && size_ok;

  logic bad_now;
  always_comb begin
    bad_now = 1'b0;
    if (!rx_line_good) begin
      bad_now = 1'b1;
    end else if (len_bad) begin
      bad_now = 1'b1;
    end else if (act) begin
      bad_now = 1'b1;
    end else begin
      bad_now = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_tdata <= 8'h00;
      rx_tvalid <= 1'b0;
      rx_tlast <= 1'b0;
      rx_tuser_bad <= 1'b0;
      rx_stat_ctrl <= 1'b0;
    end else begin
      rx_tdata <= rx_line_data;
      rx_tvalid <= rx_line_valid;
      rx_tlast <= rx_end;
      rx_tuser_bad <= rx_end && bad_now;
      rx_stat_ctrl <= rx_end && is_ctrl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acted_r <= 16'h0000;
    end else if (act) begin
      acted_r <= acted_r + 16'h0001;
    end
  end

  // Quantum length by link speed
  always_comb begin
    q_cyc = QCNT_W'(QUANT_CYC_1G);
    case (speed)
      SPEED_1G: q_cyc = QCNT_W'(QUANT_CYC_1G);
      SPEED_100M: q_cyc = QCNT_W'(QUANT_CYC_100M);
      SPEED_10M: q_cyc = QCNT_W'(QUANT_CYC_10M_P);
      default: q_cyc = QCNT_W'(QUANT_CYC_1G);
    endcase
  end

  mpfc_pause_timer u_pause_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(act),
    .load_val(rx_param),
    .q_cycles(q_cyc),
    .active(inhibit),
    .remaining(remaining)
  );

  property p_pause_first;
    @(posedge clk) disable iff (!rst_b)
    (tx_st_r == TX_IDLE && pend_r && tx_fc_en) |=>
      (tx_st_r == TX_PAUSE) ##1 (tx_line_valid && tx_line_data == 8'h01);
  endproperty
  a_pause_first: assert property (p_pause_first)
    else $error("pending pause frame not sent first from idle");

  property p_pause_len;
    @(posedge clk) disable iff (!rst_b)
    (tx_st_r == TX_PAUSE && pidx_r == 6'd0) |=>
      (tx_line_valid && !tx_line_last) ##59 (tx_line_valid && tx_line_last);
  endproperty
  a_pause_len: assert property (p_pause_len)
    else $error("pause frame length is not sixty bytes before the FCS");

  property p_pause_param;
    @(posedge clk) disable iff (!rst_b)
    (tx_st_r == TX_PAUSE && pidx_r == 6'd16) |=>
      (tx_line_data == $past(send_param_r[15:8])) ##1
      (tx_line_data == send_param_r[7:0]);
  endproperty
  a_pause_param: assert property (p_pause_param)
    else $error("pause parameter field does not carry sampled value");

  property p_latest_val;
    @(posedge clk) disable iff (!rst_b)
    (pause_req && tx_fc_en) |=> (pend_r && val_r == $past(pause_val));
  endproperty
  a_latest_val: assert property (p_latest_val)
    else $error("pause request not held with its latest duration");

  property p_holdoff;
    @(posedge clk) disable iff (!rst_b)
    (tx_st_r == TX_IDLE && inhibit) |=> !tx_tready;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("user stream accepted a new frame during hold-off");

  property p_fc_off;
    @(posedge clk) disable iff (!rst_b)
    (tx_st_r == TX_IDLE && !tx_fc_en) |=> (tx_st_r != TX_PAUSE);
  endproperty
  a_fc_off: assert property (p_fc_off)
    else $error("pause frame sent with transmit flow control off");

  property p_acted_bad;
    @(posedge clk) disable iff (!rst_b)
    act |=> (rx_tlast && rx_tuser_bad && inhibit == (remaining != 16'h0000));
  endproperty
  a_acted_bad: assert property (p_acted_bad)
    else $error("acted pause frame not forwarded marked bad");

  property p_bad_fcs;
    @(posedge clk) disable iff (!rst_b)
    (rx_end && !rx_line_good) |=> (rx_tlast && rx_tuser_bad);
  endproperty
  a_bad_fcs: assert property (p_bad_fcs)
    else $error("errored frame forwarded as good");

  property p_len_bad;
    @(posedge clk) disable iff (!rst_b)
    (rx_end && is_ctrl && len_chk_en && !len64) |->
      !act ##1 (rx_tuser_bad && rx_stat_ctrl);
  endproperty
  a_len_bad: assert property (p_len_bad)
    else $error("wrong length control frame not ignored and marked bad");

  property p_mismatch_good;
    @(posedge clk) disable iff (!rst_b)
    (rx_end && rx_line_good && !len_bad && !(da_hit && op_hit)) |=>
      (rx_tlast && !rx_tuser_bad);
  endproperty
  a_mismatch_good: assert property (p_mismatch_good)
    else $error("non-matching frame forwarded marked bad");

  property p_cancel;
    @(posedge clk) disable iff (!rst_b)
    (act && rx_param == 16'h0000) |=> (!inhibit && remaining == 16'h0000);
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("zero duration pause did not end the hold-off");

  property p_ctrl_stat;
    @(posedge clk) disable iff (!rst_b)
    rx_end |=> (rx_stat_ctrl == $past(is_ctrl));
  endproperty
  a_ctrl_stat: assert property (p_ctrl_stat)
    else $error("control frame statistics bit wrong");

endmodule : mpfc_flow_ctrl

//--- mpfc_link_model.sv
// Link partner model that feeds received frames into the block
module mpfc_link_model (
  input wire logic clk,
  output logic [7:0] rx_line_data,
  output logic rx_line_valid,
  output logic rx_line_last,
  output logic rx_line_good
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rx_line_data = 8'h00;
    rx_line_valid = 1'b0;
    rx_line_last = 1'b0;
    rx_line_good = 1'b0;
  end

  // Header is DA, SA, type, opcode, parameter; the rest is zero pad
  task automatic send(input logic [15:0] typ, input logic [15:0] op,
                      input logic [15:0] prm, input int len,
                      input logic good);
    logic [7:0] h [18];
    h = '{8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01, 8'hA0, 8'hA1, 8'hA2,
          8'hA3, 8'hA4, 8'hA5, typ[15:8], typ[7:0], op[15:8], op[7:0],
          prm[15:8], prm[7:0]};
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      rx_line_data <= (i < 18) ? h[i] : 8'h00;
      rx_line_valid <= 1'b1;
      rx_line_last <= (i == len - 1);
      rx_line_good <= (i == len - 1) ? good : ~good;
    end
    // A released line shows the inverse of its last value
    @(posedge clk);
    rx_line_valid <= 1'b0;
    rx_line_last <= 1'b0;
    rx_line_data <= ~rx_line_data;
    rx_line_good <= ~rx_line_good;
  endtask : send
endmodule : mpfc_link_model

//--- mpfc_flow_ctrl_tb.sv
// Self-checking testbench of the pause flow control block
module mpfc_flow_ctrl_tb;
  import mpfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pause_req = 1'b0;
  logic [15:0] pause_val = '0;
  logic [7:0] tx_tdata = '0;
  logic tx_tvalid = 1'b0;
  logic tx_tlast = 1'b0;
  logic tx_tready, tx_line_valid, tx_line_last;
  logic [7:0] tx_line_data, rx_line_data, rx_tdata;
  logic rx_line_valid, rx_line_last, rx_line_good;
  logic rx_tvalid, rx_tlast, rx_tuser_bad, rx_stat_ctrl;
  logic rbad, rstat;
  logic [7:0] txq [$];
  int nfr = 0;
  int failures = 0;
  int n_compared = 0;

  mpfc_flow_ctrl #(.QUANT_CYC_10M_P(8)) i_mpfc_flow_ctrl (.clk(clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pause_req(pause_req), .pause_val(pause_val), .tx_tdata(tx_tdata),
    .tx_tvalid(tx_tvalid), .tx_tlast(tx_tlast), .tx_tready(tx_tready),
    .tx_line_data(tx_line_data), .tx_line_valid(tx_line_valid),
    .tx_line_last(tx_line_last), .rx_line_data(rx_line_data),
    .rx_line_valid(rx_line_valid), .rx_line_last(rx_line_last),
    .rx_line_good(rx_line_good), .rx_tdata(rx_tdata),
    .rx_tvalid(rx_tvalid), .rx_tlast(rx_tlast),
    .rx_tuser_bad(rx_tuser_bad), .rx_stat_ctrl(rx_stat_ctrl));

  mpfc_link_model i_mpfc_link_model (.clk(clk),
    .rx_line_data(rx_line_data), .rx_line_valid(rx_line_valid),
    .rx_line_last(rx_line_last), .rx_line_good(rx_line_good));

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tx_line_valid === 1'b1) txq.push_back(tx_line_data);
    if (tx_line_last === 1'b1) nfr++;
    if (rx_tlast === 1'b1) begin
      rbad = rx_tuser_bad;
      rstat = rx_stat_ctrl;
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand only in this cycle; take them mid-cycle
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic req(input logic [15:0] v);
    @(posedge clk);
    pause_req <= 1'b1;
    pause_val <= v;
    @(posedge clk);
    pause_req <= 1'b0;
  endtask : req

  function automatic logic [7:0] ubyte(input int i);
    return (i == 12) ? 8'h88 : (i == 13) ? 8'h08 : 8'(i);
  endfunction : ubyte

  // Sends a user frame; w counts cycles before the first byte is taken
  task automatic user_tx(input int n, output int w);
    int i;
    int c;
    i = 0;
    c = 0;
    w = 0;
    @(posedge clk);
    tx_tvalid <= 1'b1;
    tx_tdata <= ubyte(0);
    tx_tlast <= (n == 1);
    while (i < n) begin
      @(posedge clk);
      c++;
      if (tx_tready === 1'b1) i++;
      else if (i == 0) w++;
      if (i < n) begin
        tx_tdata <= ubyte(i);
        tx_tlast <= (i == n - 1);
      end
      if (w > 600 || c > 700) begin
        failures++;
        print_verdict();
      end
    end
    tx_tvalid <= 1'b0;
    tx_tlast <= 1'b0;
  endtask : user_tx

  task automatic wait_tx(input int n);
    int k;
    k = 0;
    while (txq.size() < n) begin
      @(posedge clk);
      k++;
      if (k > 300) begin
        failures++;
        print_verdict();
      end
    end
  endtask : wait_tx

  task automatic chk_pause(input int s, input logic [15:0] p);
    logic [7:0] e [18];
    e = '{8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01, 8'h11, 8'h22, 8'h33,
          8'h44, 8'h55, 8'h66, 8'h88, 8'h08, 8'h00, 8'h01, p[15:8], p[7:0]};
    for (int i = 0; i < 18; i++) chk(txq[s + i], e[i]);
  endtask : chk_pause

  task automatic t_regs();
    logic [31:0] d;
    rd(REG_CONFIG, d);
    chk(d, CONFIG_RST);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, d);
    chk(d, 32'h0);
    wr(REG_STA_LO, 32'h44332211);
    wr(REG_STA_HI, 32'h00006655);
    rd(REG_STA_HI, d);
    chk(d[15:0], 16'h6655);
    wr(REG_CONFIG, 32'h07);
    $display("test regs done");
  endtask : t_regs

  task automatic t_send();
    int w;
    txq.delete();
    nfr = 0;
    fork
      user_tx(20, w);
      begin
        repeat (4) @(posedge clk);
        req(16'h0005);
        req(16'h0009);
      end
    join
    wait_tx(80);
    repeat (10) @(posedge clk);
    for (int i = 0; i < 20; i++) chk(txq[i], ubyte(i));
    chk_pause(20, 16'h0009);
    chk(txq.size(), 80);
    chk(nfr, 2);
    $display("test send done");
  endtask : t_send

  task automatic t_rx();
    logic [7:0] cfg [8] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h05, 8'h05,
                            8'h03, 8'h07};
    logic [15:0] typ [8] = '{16'h8808, 16'h8808, 16'h8808, 16'h0800,
                             16'h8808, 16'h8808, 16'h8808, 16'h8808};
    logic [15:0] op [8] = '{16'h0002, 16'h0001, 16'h0001, 16'h0001,
                            16'h0001, 16'h0001, 16'h0001, 16'h0001};
    int len [8] = '{64, 64, 65, 64, 64, 65, 70, 64};
    logic good [8] = '{1, 0, 1, 1, 1, 1, 1, 1};
    logic bad [8] = '{0, 1, 1, 0, 0, 1, 1, 1};
    logic hold [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
    int w;
    for (int k = 0; k < 8; k++) begin
      wr(REG_CONFIG, {24'h0, cfg[k]});
      // Stale flags from the last frame must not pass a missing tlast
      rbad = 1'bx;
      rstat = 1'bx;
      i_mpfc_link_model.send(typ[k], op[k], 16'h0003, len[k], good[k]);
      repeat (2) @(posedge clk);
      chk(rbad, bad[k]);
      chk(rstat, typ[k] == 16'h8808);
      user_tx(2, w);
      chk(hold[k] ? (w >= 14 && w <= 34) : (w <= 4), 1);
    end
    $display("test receive done");
  endtask : t_rx

  task automatic t_cancel();
    logic [31:0] d;
    int w;
    wr(REG_CONFIG, 32'h07);
    i_mpfc_link_model.send(16'h8808, 16'h0001, 16'hFFFF, 64, 1'b1);
    repeat (2) @(posedge clk);
    txq.delete();
    req(16'h1234);
    wait_tx(60);
    chk_pause(0, 16'h1234);
    rd(REG_STATUS, d);
    chk(d[0], 1'b1);
    i_mpfc_link_model.send(16'h8808, 16'h0001, 16'h0000, 64, 1'b1);
    repeat (2) @(posedge clk);
    user_tx(2, w);
    chk(w <= 4, 1);
    rd(REG_STATUS, d);
    chk(d[0], 1'b0);
    $display("test cancel done");
  endtask : t_cancel

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_send();
    t_rx();
    t_cancel();
    print_verdict();
  end
endmodule : mpfc_flow_ctrl_tb
